// *** rtl/rtc_pkg.sv ***
// Constants shared by the calendar clock and its backup store
package rtc_pkg;
   localparam int          XTAL_HZ         = 32768;
   localparam logic [6:0]  PREDIV_A_RST    = 7'h7F;
   localparam logic [14:0] PREDIV_S_RST    = 15'h00FF;
   localparam int          CAL_WIN_BITS    = 20;
   localparam int          CAL_ADD_BITS    = 11;
   localparam logic [5:0]  REF_EDGES_50    = 6'h32;
   localparam logic [5:0]  REF_EDGES_60    = 6'h3C;
   localparam int          BKP_WORDS       = 32;
   localparam int          BKP_WIDTH       = 32;
   localparam logic [31:0] BKP_RST         = 32'h0000_0000;
   localparam logic [7:0]  TIME_RST        = 8'h00;
   localparam logic [7:0]  DATE_RST        = 8'h01;
   localparam logic [7:0]  YEAR_RST        = 8'h00;
   localparam logic [2:0]  WDAY_RST        = 3'h1;
   localparam logic [2:0]  WDAY_LAST       = 3'h7;
   localparam logic [7:0]  SEC_LAST        = 8'h59;
   localparam logic [7:0]  HOUR_LAST       = 8'h23;
   localparam logic [7:0]  MON_LAST        = 8'h12;
   localparam logic [7:0]  YEAR_LAST       = 8'h99;
   localparam logic [15:0] WAKE_RST        = 16'hFFFF;
endpackage

// *** rtl/backup_mem.sv ***
// Backup word store, wiped as a whole on tamper
`timescale 1ns/1ps
module backup_mem #(
   parameter int WORDS = rtc_pkg::BKP_WORDS,
   parameter int WIDTH = rtc_pkg::BKP_WIDTH
) (
   input  wire logic                     ref_clk,
   input  wire logic                     rstn,
   input  wire logic                     wipe,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(WORDS)-1:0] addr,
   input  wire logic [WIDTH-1:0]         wdata,
   output logic      [WIDTH-1:0]         rdata
);
   import rtc_pkg::*;

   logic [WIDTH-1:0] mem_reg [WORDS];

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < WORDS; i++) begin
            mem_reg[i] <= WIDTH'(BKP_RST);
         end
      end else if (wipe) begin
         for (int i = 0; i < WORDS; i++) begin
            mem_reg[i] <= WIDTH'(BKP_RST);
         end
      end else if (wr_en) begin
         mem_reg[addr] <= wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= '0;
      end else begin
         rdata <= mem_reg[addr];
      end
   end
endmodule

// *** rtl/rtc_calendar_backup.sv ***
// Calendar clock with prescaler, alarms, time stamp, tamper, wakeup and backup words
`timescale 1ns/1ps
module rtc_calendar_backup (
   input  wire logic                  ref_clk,
   input  wire logic                  rstn,
   input  wire logic                  xtal_clk_in,
   input  wire logic                  cfg_wr,
   input  wire logic [6:0]            cfg_prediv_a,
   input  wire logic [14:0]           cfg_prediv_s,
   input  wire logic [8:0]            cal_minus,
   input  wire logic                  cal_plus,
   input  wire logic                  ref_det_en,
   input  wire logic                  ref_sel_60hz,
   input  wire logic                  ref_clk_in,
   input  wire logic                  set_time,
   input  wire logic [23:0]           set_hms,
   input  wire logic [23:0]           set_ymd,
   input  wire logic [2:0]            set_wday,
   input  wire logic                  shift_req,
   input  wire logic [14:0]           shift_subfs,
   input  wire logic                  shift_add1s,
   input  wire logic                  dst_add_hour,
   input  wire logic                  dst_sub_hour,
   input  wire logic [1:0]            alarm_en,
   input  wire logic [1:0][31:0]      alarm_value,
   input  wire logic [1:0][3:0]       alarm_mask,
   input  wire logic [1:0]            alarm_ie,
   input  wire logic [1:0]            alarm_clr,
   input  wire logic                  ts_in,
   input  wire logic                  ts_en,
   input  wire logic                  ts_ie,
   input  wire logic                  ts_clr,
   input  wire logic                  tamper_input_0,
   input  wire logic                  tamper_input_1,
   input  wire logic                  tamper_input_2,
   input  wire logic [2:0]            tamper_en,
   input  wire logic [2:0]            tamper_level,
   input  wire logic                  tamper_ts_en,
   input  wire logic                  tamper_ie,
   input  wire logic [2:0]            tamper_clr,
   input  wire logic                  wake_en,
   input  wire logic                  wake_clk_sel,
   input  wire logic [15:0]           wake_reload,
   input  wire logic                  wake_ie,
   input  wire logic                  wake_clr,
   input  wire logic                  bkp_wr,
   input  wire logic [4:0]            bkp_addr,
   input  wire logic [31:0]           bkp_wdata,
   output logic      [31:0]           bkp_rdata,
   output logic      [7:0]            hours,
   output logic      [7:0]            minutes,
   output logic      [7:0]            seconds,
   output logic      [14:0]           subsec,
   output logic      [7:0]            year,
   output logic      [7:0]            month,
   output logic      [7:0]            mday,
   output logic      [2:0]            wday,
   output logic      [1:0]            alarm_flag,
   output logic      [1:0]            alarm_irq,
   output logic      [23:0]           ts_hms,
   output logic      [23:0]           ts_ymd,
   output logic                       ts_flag,
   output logic                       ts_ovf,
   output logic                       ts_irq,
   output logic      [2:0]            tamper_flag,
   output logic                       tamper_irq,
   output logic                       wake_flag,
   output logic                       wake_irq
);
   import rtc_pkg::*;

   // Returns {carry, next} for a BCD field stepping from lo up to hi
   function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] lo,
                                           input logic [7:0] hi);
      if (v >= hi) begin
         bcd_step = {1'b1, lo};
      end else if (v[3:0] == 4'h9) begin
         bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_step = {1'b0, v + 8'h01};
      end
   endfunction

   function automatic logic leap(input logic [7:0] y);
      if (y[4]) begin
         leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end else begin
         leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      end
   endfunction

   function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
      case (m)
         8'h02:   month_last = leap(y) ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
         default: month_last = 8'h31;
      endcase
   endfunction

   logic [6:0]  prediv_a_reg;
   logic [14:0] prediv_s_reg;
   logic        xtal_reg, xtal_d_reg, ref_reg, ref_d_reg, ts_d_reg;
   logic [2:0]  tamp_d_reg;
   logic [CAL_WIN_BITS-1:0] cal_cnt_reg;
   logic        add_pend_reg;
   logic [6:0]  pa_reg;
   logic [14:0] ss_reg;
   logic [5:0]  ref_cnt_reg;
   logic [15:0] wake_cnt_reg;
   logic        tick_d_reg;
   logic [7:0]  sec_next, min_next, hour_next, day_next, mon_next, year_next;
   logic [2:0]  wday_next;
   logic [8:0]  s_step, m_step, h_step, d_step, mo_step, y_step;
   logic        xedge, ck_pulse, ss_wrap, ref_edge, ref_tick, sec_tick;
   logic [15:0] shift_sum;
   logic [14:0] shifted_ss;
   logic [2:0]  tamp_now, tamp_hit;
   logic        ts_event, wipe, wake_step;
   logic [1:0]  alarm_hit;

   // Configuration held in the backup domain; only rstn clears it
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         prediv_a_reg <= PREDIV_A_RST;
         prediv_s_reg <= PREDIV_S_RST;
      end else if (cfg_wr) begin
         prediv_a_reg <= cfg_prediv_a;
         prediv_s_reg <= cfg_prediv_s;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         xtal_reg   <= 1'b0;
         xtal_d_reg <= 1'b0;
         ref_reg    <= 1'b0;
         ref_d_reg  <= 1'b0;
         ts_d_reg   <= 1'b0;
         tamp_d_reg <= 3'h7;
      end else begin
         xtal_reg   <= xtal_clk_in;
         xtal_d_reg <= xtal_reg;
         ref_reg    <= ref_clk_in;
         ref_d_reg  <= ref_reg;
         ts_d_reg   <= ts_in;
         tamp_d_reg <= tamp_now ~^ tamper_level;
      end
   end

   assign xedge    = xtal_reg & ~xtal_d_reg;
   assign ref_edge = ref_reg & ~ref_d_reg;

   // Drop the first cal_minus crystal edges of each window, or add one
   // pulse every 2^11 edges (512 per window) when cal_plus is set
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cal_cnt_reg  <= '0;
         add_pend_reg <= 1'b0;
      end else begin
         if (xedge) begin
            cal_cnt_reg <= cal_cnt_reg + 1'b1;
         end
         add_pend_reg <= xedge & cal_plus & (cal_cnt_reg[CAL_ADD_BITS-1:0] == '0);
      end
   end

   assign ck_pulse = (xedge & (cal_cnt_reg >= CAL_WIN_BITS'(cal_minus))) | add_pend_reg;

   assign shift_sum  = {1'b0, ss_reg} + {1'b0, shift_subfs};
   assign shifted_ss = (shift_sum > {1'b0, prediv_s_reg}) ?
                       15'(shift_sum - {1'b0, prediv_s_reg} - 16'h0001) : shift_sum[14:0];
   assign ss_wrap    = ck_pulse && (pa_reg == '0) && (ss_reg == '0);
   assign ref_tick   = ref_det_en && ref_edge &&
                       (ref_cnt_reg == (ref_sel_60hz ? REF_EDGES_60 : REF_EDGES_50) - 6'h01);
   assign sec_tick   = (ref_det_en ? ref_tick : ss_wrap) | (shift_req & shift_add1s);

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pa_reg <= PREDIV_A_RST;
         ss_reg <= PREDIV_S_RST;
      end else if (set_time || cfg_wr) begin
         pa_reg <= cfg_wr ? cfg_prediv_a : prediv_a_reg;
         ss_reg <= cfg_wr ? cfg_prediv_s : prediv_s_reg;
      end else if (shift_req) begin
         ss_reg <= shifted_ss;
      end else if (ref_tick) begin
         pa_reg <= prediv_a_reg;
         ss_reg <= prediv_s_reg;
      end else if (ck_pulse) begin
         if (pa_reg == '0) begin
            pa_reg <= prediv_a_reg;
            ss_reg <= (ss_reg == '0) ? prediv_s_reg : ss_reg - 15'h0001;
         end else begin
            pa_reg <= pa_reg - 7'h01;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ref_cnt_reg <= '0;
      end else if (!ref_det_en || ref_tick) begin
         ref_cnt_reg <= '0;
      end else if (ref_edge) begin
         ref_cnt_reg <= ref_cnt_reg + 6'h01;
      end
   end

   always_comb begin
      s_step    = bcd_step(seconds, TIME_RST, SEC_LAST);
      m_step    = bcd_step(minutes, TIME_RST, SEC_LAST);
      h_step    = bcd_step(hours, TIME_RST, HOUR_LAST);
      d_step    = bcd_step(mday, DATE_RST, month_last(month, year));
      mo_step   = bcd_step(month, DATE_RST, MON_LAST);
      y_step    = bcd_step(year, YEAR_RST, YEAR_LAST);
      sec_next  = seconds;
      min_next  = minutes;
      hour_next = hours;
      day_next  = mday;
      mon_next  = month;
      year_next = year;
      wday_next = wday;
      if (sec_tick) begin
         sec_next = s_step[7:0];
         if (s_step[8]) begin
            min_next = m_step[7:0];
            if (m_step[8]) begin
               hour_next = h_step[7:0];
               if (h_step[8]) begin
                  wday_next = (wday == WDAY_LAST) ? WDAY_RST : wday + 3'h1;
                  day_next  = d_step[7:0];
                  if (d_step[8]) begin
                     mon_next = mo_step[7:0];
                     if (mo_step[8]) begin
                        year_next = y_step[7:0];
                     end
                  end
               end
            end
         end
      end
      // One-hour steps stay within the day; a request at the day edge is ignored
      if (dst_add_hour && hour_next != HOUR_LAST) begin
         hour_next = 8'(bcd_step(hour_next, TIME_RST, HOUR_LAST));
      end else if (dst_sub_hour && hour_next != TIME_RST) begin
         hour_next = (hour_next[3:0] == 4'h0) ? {hour_next[7:4] - 4'h1, 4'h9} :
                     hour_next - 8'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         seconds <= TIME_RST;
         minutes <= TIME_RST;
         hours   <= TIME_RST;
         mday    <= DATE_RST;
         month   <= DATE_RST;
         year    <= YEAR_RST;
         wday    <= WDAY_RST;
      end else if (set_time) begin
         {hours, minutes, seconds} <= set_hms;
         {year, month, mday}       <= set_ymd;
         wday                      <= set_wday;
      end else begin
         seconds <= sec_next;
         minutes <= min_next;
         hours   <= hour_next;
         mday    <= day_next;
         month   <= mon_next;
         year    <= year_next;
         wday    <= wday_next;
      end
   end

   assign subsec = ss_reg;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tick_d_reg <= 1'b0;
      end else begin
         tick_d_reg <= sec_tick & ~set_time;
      end
   end

   // Fields: [31:24] day of month, [23:16] hours, [15:8] minutes, [7:0] seconds;
   // mask bit 3..0 drops day, hours, minutes, seconds from the compare
   for (genvar a = 0; a < 2; a++) begin : g_alarm
      assign alarm_hit[a] = alarm_en[a] && tick_d_reg &&
         (alarm_mask[a][3] || alarm_value[a][31:24] == mday) &&
         (alarm_mask[a][2] || alarm_value[a][23:16] == hours) &&
         (alarm_mask[a][1] || alarm_value[a][15:8] == minutes) &&
         (alarm_mask[a][0] || alarm_value[a][7:0] == seconds);

      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) begin
            alarm_flag[a] <= 1'b0;
         end else if (alarm_hit[a]) begin
            alarm_flag[a] <= 1'b1;
         end else if (alarm_clr[a]) begin
            alarm_flag[a] <= 1'b0;
         end
      end
   end

   assign alarm_irq = alarm_flag & alarm_ie;

   assign tamp_now = {tamper_input_2, tamper_input_1, tamper_input_0};
   // Previous match starts as set, so leaving reset is never an event
   assign tamp_hit = tamper_en & (tamp_now ~^ tamper_level) & ~tamp_d_reg;
   assign wipe     = |tamp_hit;
   assign ts_event = (ts_en & ts_in & ~ts_d_reg) | (tamper_ts_en & wipe);

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ts_hms  <= '0;
         ts_ymd  <= '0;
         ts_flag <= 1'b0;
         ts_ovf  <= 1'b0;
      end else begin
         if (ts_event) begin
            ts_hms  <= {hours, minutes, seconds};
            ts_ymd  <= {year, month, mday};
            ts_flag <= 1'b1;
            ts_ovf  <= ts_flag & ~ts_clr;
         end else if (ts_clr) begin
            ts_flag <= 1'b0;
            ts_ovf  <= 1'b0;
         end
      end
   end

   assign ts_irq = ts_flag & ts_ie;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tamper_flag <= 3'h0;
      end else begin
         tamper_flag <= tamp_hit | (tamper_flag & ~tamper_clr);
      end
   end

   assign tamper_irq = tamper_ie & (|tamper_flag);

   assign wake_step = wake_en & (wake_clk_sel ? ck_pulse : sec_tick);

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wake_cnt_reg <= WAKE_RST;
         wake_flag    <= 1'b0;
      end else begin
         if (!wake_en) begin
            wake_cnt_reg <= wake_reload;
         end else if (wake_step) begin
            wake_cnt_reg <= (wake_cnt_reg == '0) ? wake_reload : wake_cnt_reg - 16'h0001;
         end
         if (wake_step && wake_cnt_reg == '0) begin
            wake_flag <= 1'b1;
         end else if (wake_clr) begin
            wake_flag <= 1'b0;
         end
      end
   end

   assign wake_irq = wake_flag & wake_ie;

   backup_mem #(
      .WORDS (BKP_WORDS),
      .WIDTH (BKP_WIDTH)
   ) u_backup (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .wipe    (wipe),
      .wr_en   (bkp_wr),
      .addr    (bkp_addr),
      .wdata   (bkp_wdata),
      .rdata   (bkp_rdata)
   );
endmodule

// *** dv/rtc_calendar_backup_monitor.sv ***
// Port-level property checks for the calendar clock and backup words
`timescale 1ns/1ps
module rtc_calendar_backup_checker (
   input wire logic        ref_clk,
   input wire logic        rstn,
   input wire logic        set_time,
   input wire logic [23:0] set_hms,
   input wire logic [2:0]  set_wday,
   input wire logic [7:0]  hours,
   input wire logic [7:0]  minutes,
   input wire logic [7:0]  seconds,
   input wire logic [2:0]  wday,
   input wire logic [1:0]  alarm_flag,
   input wire logic [1:0]  alarm_irq,
   input wire logic [1:0]  alarm_ie,
   input wire logic [1:0]  alarm_clr,
   input wire logic        ts_in,
   input wire logic        ts_en,
   input wire logic        ts_ie,
   input wire logic        ts_flag,
   input wire logic        ts_irq,
   input wire logic [23:0] ts_hms,
   input wire logic        tamper_input_0,
   input wire logic        tamper_input_1,
   input wire logic        tamper_input_2,
   input wire logic [2:0]  tamper_en,
   input wire logic [2:0]  tamper_level,
   input wire logic        tamper_ie,
   input wire logic [2:0]  tamper_flag,
   input wire logic        tamper_irq,
   input wire logic        bkp_wr,
   input wire logic [4:0]  bkp_addr,
   input wire logic [31:0] bkp_wdata,
   input wire logic [31:0] bkp_rdata
);
   import rtc_pkg::*;
   logic [2:0] tmatch;
   logic [2:0] tmatch_reg;
   logic [2:0] tevent;
   // Previous match starts as set so a reset release is never seen as an event
   assign tmatch = ~({tamper_input_2, tamper_input_1, tamper_input_0} ^ tamper_level);
   assign tevent = tamper_en & tmatch & ~tmatch_reg;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tmatch_reg <= 3'h7;
      end else begin
         tmatch_reg <= tmatch;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence wr_then_hold;
      bkp_wr && !(|tevent) ##1 !bkp_wr && $stable(bkp_addr) && !(|tevent);
   endsequence
   chk_alarm_irq_gate: assert property (alarm_irq == (alarm_flag & alarm_ie))
      else $error("alarm interrupt differs from flag and enable");
   chk_alarm_flag_hold: assert property (alarm_flag[0] && !alarm_clr[0] |=> alarm_flag[0])
      else $error("alarm flag dropped without clear");
   chk_ts_capture: assert property ($rose(ts_in) && ts_en |=>
      ts_flag && ts_hms == $past({hours, minutes, seconds}))
      else $error("time stamp not captured");
   chk_ts_irq_gate: assert property (ts_irq == (ts_flag && ts_ie))
      else $error("time stamp interrupt differs from flag and enable");
   chk_tamper_wipe: assert property (|tevent |=>
      (tamper_flag & $past(tevent)) == $past(tevent) ##1 bkp_rdata == BKP_RST)
      else $error("tamper flag or backup wipe missing");
   chk_tamper_irq_gate: assert property (tamper_irq == (tamper_ie && |tamper_flag))
      else $error("tamper interrupt differs from flags and enable");
   chk_bkp_readback: assert property (wr_then_hold |=> bkp_rdata == $past(bkp_wdata, 2))
      else $error("backup word readback differs from write");
   chk_set_time_load: assert property (set_time |=>
      {hours, minutes, seconds} == $past(set_hms) && wday == $past(set_wday))
      else $error("time load not applied");
   chk_time_bcd_range: assert property (seconds[3:0] <= 4'h9 && seconds <= SEC_LAST &&
      minutes[3:0] <= 4'h9 && minutes <= SEC_LAST)
      else $error("seconds or minutes outside BCD range");
   cov_alarm_irq: cover property (alarm_irq[0]);
   cov_tamper_wipe: cover property (|tevent ##2 tamper_irq);
   cov_bkp_read: cover property (wr_then_hold);
endmodule

bind rtc_calendar_backup rtc_calendar_backup_checker u_checker (.*);

// *** dv/tb.sv ***
// Self-checking bench for the calendar clock with backup words
`timescale 1ns/1ps
module tb;
   import rtc_pkg::*;
   logic        ref_clk, rstn, xtal_clk_in, cfg_wr, cal_plus, ref_det_en, ref_sel_60hz;
   logic        ref_clk_in, set_time, shift_req, shift_add1s, dst_add_hour, dst_sub_hour;
   logic        ts_in, ts_en, ts_ie, ts_clr, tamper_input_0, tamper_input_1, tamper_input_2;
   logic        tamper_ts_en, tamper_ie, wake_en, wake_clk_sel, wake_ie, wake_clr, bkp_wr;
   logic        ts_flag, ts_ovf, ts_irq, tamper_irq, wake_flag, wake_irq, xtal_run;
   logic [6:0]  cfg_prediv_a;
   logic [14:0] cfg_prediv_s, shift_subfs, subsec;
   logic [8:0]  cal_minus;
   logic [23:0] set_hms, set_ymd, ts_hms, ts_ymd;
   logic [2:0]  set_wday, tamper_en, tamper_level, tamper_clr, wday, tamper_flag;
   logic [1:0]  alarm_en, alarm_ie, alarm_clr, alarm_flag, alarm_irq, xdiv;
   logic [1:0][31:0] alarm_value;
   logic [1:0][3:0]  alarm_mask;
   logic [15:0] wake_reload;
   logic [4:0]  bkp_addr;
   logic [31:0] bkp_wdata, bkp_rdata;
   logic [7:0]  hours, minutes, seconds, year, month, mday;
   int          failures = 0, check_count = 0, cycles = 0, i, c0;
   logic [47:0] from_t [5] = '{48'h2359_5999_1231, 48'h2359_5900_0228, 48'h2359_5901_0228,
                               48'h2359_5905_0430, 48'h0959_5905_0607};
   logic [47:0] to_t [5] = '{48'h0000_0000_0101, 48'h0000_0000_0229, 48'h0000_0001_0301,
                             48'h0000_0005_0501, 48'h1000_0005_0607};
   logic [2:0]  wd_t [5] = '{3'h7, 3'h3, 3'h3, 3'h2, 3'h6};
   logic [2:0]  nwd_t [5] = '{3'h1, 3'h4, 3'h4, 3'h3, 3'h6};

   rtc_calendar_backup DUT (.*);

   always #4 ref_clk = ~ref_clk;
   // Crystal stand-in, far faster than real so a second lasts 16 cycles
   always @(negedge ref_clk) begin
      xdiv <= xdiv + 2'h1;
      if (xtal_run && xdiv == 2'h3) begin
         xtal_clk_in <= ~xtal_clk_in;
      end
   end
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         close_out();
      end
   end

   task automatic close_out();
      if (failures == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic wait_sec();
      logic [7:0] s;
      int k;
      s = seconds;
      k = 0;
      while (seconds === s && k < 400) begin
         step(1);
         k = k + 1;
      end
      check(k < 400, 1'h1);
   endtask
   task automatic set_clock(input logic [47:0] t, input logic [2:0] wd);
      {set_hms, set_ymd} = t;
      set_wday = wd;
      set_time = 1'h1;
      step(1);
      set_time = 1'h0;
   endtask
   task automatic bkp_write(input logic [4:0] a, input logic [31:0] d);
      bkp_addr = a;
      bkp_wdata = d;
      bkp_wr = 1'h1;
      step(1);
      bkp_wr = 1'h0;
      step(1);
   endtask
   task automatic bkp_expect(input logic [4:0] a, input logic [31:0] exp);
      bkp_addr = a;
      step(2);
      check(bkp_rdata, exp);
   endtask
   task automatic ref_pulse();
      ref_clk_in = 1'h1;
      step(2);
      ref_clk_in = 1'h0;
      step(2);
   endtask

   initial begin
      {rstn, ref_clk, xtal_clk_in, cfg_wr, cal_plus, ref_det_en, ref_sel_60hz, ref_clk_in,
       set_time, shift_req, shift_add1s, dst_add_hour, dst_sub_hour, ts_in, ts_en, ts_ie,
       ts_clr, tamper_input_1, tamper_ts_en, tamper_ie, wake_en, wake_clk_sel, wake_ie,
       wake_clr, bkp_wr, xdiv, xtal_run, cal_minus, cfg_prediv_a, cfg_prediv_s, shift_subfs,
       set_hms, set_ymd, set_wday, tamper_en, tamper_level, tamper_clr, alarm_en, alarm_ie,
       alarm_clr, alarm_value, alarm_mask, wake_reload, bkp_addr, bkp_wdata} = '0;
      tamper_input_0 = 1'h1;
      tamper_input_2 = 1'h1;
      step(12);
      rstn = 1'h1;
      step(2);
      check({hours, minutes, seconds, year, month, mday, wday}, {48'h0000_0000_0101, 3'h1});
      check(subsec, PREDIV_S_RST);
      check({alarm_flag, ts_flag, ts_ovf, tamper_flag, wake_flag, bkp_rdata}, 40'h0);
      cfg_prediv_s = 15'h0001;
      cfg_wr = 1'h1;
      step(1);
      cfg_wr = 1'h0;
      xtal_run <= 1'h1;
      wait_sec();
      c0 = cycles;
      wait_sec();
      check(cycles - c0, 32'h0000_0010);
      for (i = 0; i < 5; i++) begin
         set_clock(from_t[i], wd_t[i]);
         wait_sec();
         check({hours, minutes, seconds, year, month, mday, wday}, {to_t[i], nwd_t[i]});
      end
      alarm_value[0] = 32'h0708_3016;
      alarm_value[1] = 32'h0711_3016;
      alarm_mask[1] = 4'hE;
      alarm_en = 2'h3;
      alarm_ie = 2'h1;
      set_clock(48'h0830_1505_0607, 3'h5);
      step(3);
      check(alarm_flag, 2'h0);
      wait_sec();
      step(3);
      check({alarm_flag, alarm_irq}, 4'hD);
      alarm_clr = 2'h3;
      step(1);
      alarm_clr = 2'h0;
      check(alarm_flag, 2'h0);
      wait_sec();
      xtal_run <= 1'h0;
      step(3);
      check(alarm_flag, 2'h0);
      {ts_en, ts_ie, ts_in} = 3'h7;
      step(2);
      check({ts_flag, ts_irq, ts_ovf, ts_hms, ts_ymd}, {3'h6, 48'h0830_1705_0607});
      ts_in = 1'h0;
      step(1);
      ts_in = 1'h1;
      step(2);
      check(ts_ovf, 1'h1);
      {ts_clr, ts_in} = 2'h2;
      step(1);
      ts_clr = 1'h0;
      check(ts_flag, 1'h0);
      ref_det_en = 1'h1;
      for (i = 0; i < 2; i++) begin
         ref_sel_60hz = i[0];
         repeat ((i == 1 ? REF_EDGES_60 : REF_EDGES_50) - 1) ref_pulse();
         check(seconds, 8'h17 + i);
         ref_pulse();
         check(seconds, 8'h18 + i);
      end
      ref_det_en = 1'h0;
      shift_subfs = 15'h0001;
      {shift_add1s, shift_req} = 2'h3;
      step(1);
      {shift_add1s, shift_req} = 2'h0;
      step(1);
      check(seconds, 8'h20);
      check(subsec, 15'h0000);
      dst_add_hour = 1'h1;
      step(1);
      dst_add_hour = 1'h0;
      check(hours, 8'h09);
      dst_sub_hour = 1'h1;
      step(1);
      dst_sub_hour = 1'h0;
      check(hours, 8'h08);
      bkp_write(5'h00, 32'hA5A5_0001);
      bkp_write(5'h1F, 32'h5A5A_001F);
      bkp_expect(5'h00, 32'hA5A5_0001);
      {tamper_level, tamper_en, tamper_ie, tamper_input_0} = 8'h5F;
      step(2);
      check({tamper_flag, tamper_irq}, 4'h0);
      bkp_expect(5'h1F, 32'h5A5A_001F);
      tamper_input_2 = 1'h0;
      step(2);
      check({tamper_flag, tamper_irq}, 4'h9);
      bkp_expect(5'h1F, BKP_RST);
      bkp_expect(5'h00, BKP_RST);
      tamper_clr = 3'h7;
      step(1);
      tamper_clr = 3'h0;
      check(tamper_flag, 3'h0);
      bkp_write(5'h05, 32'h1234_5678);
      {tamper_ts_en, tamper_input_1} = 2'h3;
      step(2);
      check({tamper_flag, ts_flag}, 4'h5);
      bkp_expect(5'h05, BKP_RST);
      cal_minus = 9'h1FF;
      xtal_run <= 1'h1;
      step(40);
      check(seconds, 8'h20);
      cal_minus = 9'h000;
      {wake_clk_sel, wake_ie, wake_reload} = {2'h3, 16'h0002};
      xtal_run <= 1'h1;
      wake_en = 1'h1;
      step(4);
      check(wake_flag, 1'h0);
      for (i = 0; i < 400 && wake_flag !== 1'h1; i++) step(1);
      check({wake_flag, wake_irq}, 2'h3);
      {wake_en, wake_clr} = 2'h1;
      step(1);
      wake_clr = 1'h0;
      check(wake_flag, 1'h0);
      close_out();
   end
endmodule
